// >>> hw/lld_pkg.sv
// Constants, register map and types of the link debounce fabric
package lld_pkg;
  // Timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned DELAY_MS = 20;
  localparam int unsigned DELAY_CYC = CLK_HZ / 1000 * DELAY_MS;
  ////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [4:0] A_SRC0 = 5'h00;
  localparam logic [4:0] A_SRC1 = 5'h01;
  localparam logic [4:0] A_SRC6 = 5'h02;
  localparam logic [4:0] A_PICK0 = 5'h03;
  localparam logic [4:0] A_PICK1 = 5'h04;
  localparam logic [4:0] A_PICK2 = 5'h05;
  localparam logic [4:0] A_PICK6 = 5'h06;
  localparam logic [4:0] A_ROUTE0 = 5'h07;
  localparam logic [4:0] A_ROUTE1 = 5'h08;
  localparam logic [4:0] A_ROUTE2 = 5'h09;
  localparam logic [4:0] A_ROUTE6 = 5'h0A;
  localparam logic [4:0] A_CTL = 5'h0B;
  localparam logic [4:0] A_SINK0 = 5'h0C;
  localparam logic [4:0] A_SINK3 = 5'h0D;
  localparam logic [4:0] A_DEST = 5'h0E;
  localparam logic [4:0] A_TCFG = 5'h0F;
  localparam logic [4:0] A_STAT = 5'h10;
  localparam logic [4:0] A_MASK = 5'h11;
  localparam logic [4:0] A_STATE = 5'h12;
  // Reset values, indexed by offset 00H..0FH
  localparam logic [7:0] CFG_RST [0:15] = '{8'h1B, 8'h1D, 8'h16, 8'h01, 8'h02, 8'h82, 8'h01, 8'h01,
                                             8'h02, 8'h09, 8'h02, 8'h83, 8'h05, 8'h01, 8'h00, 8'h00};
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  ////////////////////////////////////////////////////////////
  // Source codes
  localparam logic [7:0] C_RAW = 8'h1B;
  localparam logic [7:0] C_FB = 8'h1D;
  localparam logic [7:0] C_EV0 = 8'h16;
  localparam logic [7:0] C_EV1 = 8'h17;
  localparam logic [7:0] C_EV5 = 8'h18;
  // Pick, route and control fields
  localparam int unsigned PICK_INV_BIT = 7;
  localparam logic [1:0] PICK_A = 2'h1;
  localparam logic [1:0] PICK_B = 2'h2;
  localparam logic [7:0] ROUTE_IN0 = 8'h01;
  localparam logic [7:0] ROUTE_IN1 = 8'h02;
  localparam logic [7:0] ROUTE_FFD = 8'h09;
  localparam logic [7:0] ROUTE_CLK = 8'h02;
  localparam int unsigned CTL_FF_EN_BIT = 7;
  localparam logic [1:0] FN_AND = 2'h0;
  localparam logic [1:0] FN_OR = 2'h1;
  localparam logic [1:0] FN_NAND = 2'h2;
  localparam logic [1:0] FN_XOR = 2'h3;
  // Timer config: bit 0 rising edge, bits 2:1 channel
  localparam int unsigned TCFG_EDGE_BIT = 0;
  localparam logic [1:0] CH0 = 2'h0;
  localparam logic [1:0] CH1 = 2'h1;
  localparam logic [1:0] CH5 = 2'h2;
  // Status bits
  localparam int unsigned ST_DONE = 0;
  localparam int unsigned ST_CHG = 1;
  // Destinations of sink 0
  typedef enum logic [2:0] {
    DST_PIN = 3'h0, DST_IRQ = 3'h1, DST_XFER = 3'h2, DST_SEQ = 3'h3,
    DST_ADC = 3'h4, DST_TOUCH = 3'h5, DST_CAP = 3'h6
  } lld_dest_t;
  typedef enum logic [1:0] {T_IDLE = 2'b00, T_COUNT = 2'b01, T_FIRE = 2'b11} lld_tstate_t;
endpackage

// >>> hw/lld_tmr_if.sv
// Link between the fabric and the delay timer channel
`timescale 1ns/100ps
interface lld_tmr_if;
  logic lvl;
  logic done;
  logic busy;
  modport fab (output lvl, input done, input busy);
  modport tmr (input lvl, output done, output busy);
endinterface // lld_tmr_if

// >>> hw/lld_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module lld_sync3 (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic q_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      q_ff <= 1'b0;
    end else begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // Output updates only once stages two and three agree
      if (s2_ff == s3_ff) begin
        q_ff <= s3_ff;
      end
    end
  end
  assign q_o = q_ff;
endmodule // lld_sync3

// >>> hw/lld_delay_timer.sv
// Delay counter channel started by an edge of its input
`timescale 1ns/100ps
module lld_delay_timer #(
  parameter int unsigned DELAY_CYC = lld_pkg::DELAY_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rise_i,
  lld_tmr_if.tmr tif
);
  if (DELAY_CYC < 2) begin : g_chk
    $error("DELAY_CYC below 2");
  end
  localparam int unsigned CW = $clog2(DELAY_CYC);
  localparam logic [CW-1:0] LAST = CW'(DELAY_CYC - 1);
  lld_pkg::lld_tstate_t st_ff, nxt_st;
  logic [CW-1:0] cnt_ff;
  logic lvl_ff;
  wire trig = rise_i ? (tif.lvl && !lvl_ff) : (!tif.lvl && lvl_ff);
  // Input back at its idle level ends the wait early
  wire idle_lvl = rise_i ? !tif.lvl : tif.lvl;
  // [RULE16] delay counter
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      lld_pkg::T_IDLE: if (trig) nxt_st = lld_pkg::T_COUNT;
      lld_pkg::T_COUNT: begin
        if (idle_lvl) nxt_st = lld_pkg::T_IDLE;
        else if (!trig && cnt_ff == LAST) nxt_st = lld_pkg::T_FIRE;
      end
      lld_pkg::T_FIRE: nxt_st = trig ? lld_pkg::T_COUNT : lld_pkg::T_IDLE;
      default: nxt_st = lld_pkg::T_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= lld_pkg::T_IDLE;
      cnt_ff <= '0;
      lvl_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      lvl_ff <= tif.lvl;
      cnt_ff <= (trig || nxt_st != lld_pkg::T_COUNT) ? '0 : cnt_ff + 1'b1;
    end
  end
  assign tif.done = (st_ff == lld_pkg::T_FIRE);
  assign tif.busy = (st_ff == lld_pkg::T_COUNT);
  // [RULE16] fire after full delay
  AST_DELAY_LEN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(tif.done) |-> $past(cnt_ff) == LAST) // [RULE16]
    else $error("done without full delay");
endmodule // lld_delay_timer

// >>> hw/lld_link_debounce.sv
// Logic and event link fabric set up as a switch chatter filter
// Summary of operation
// [RULE1] Source selector 0 code 1BH brings the raw switch pin in.
// [RULE2] Source selector 1 code 1DH feeds back block one flip-flop 1.
// [RULE3] Source selector 6 code 16H brings timer channel 0 done event in.
// [RULE4] Picks 0, 1, 6 take sources 0, 1, 6 true with 01H, 02H, 01H.
// [RULE5] Pick 2 code 82H takes source 1 inverted.
// [RULE6] Routes 01H, 02H steer picks 0, 1 to cell 0 inputs 0, 1.
// [RULE7] Route 09H steers pick 2 to flip-flop 1 data.
// [RULE8] Route 02H steers pick 6 to flip-flop 1 clock.
// [RULE9] Control 83H enables flip-flop 1 and makes cell 0 an XOR.
// [RULE10] Sink 0 code 05H forwards block output 4 to the filtered pin.
// [RULE11] Sink 3 code 01H forwards block output 0 to the timer input.
// [RULE12] Flip-flop clock is the done event of the chosen timer channel.
// [RULE13] Software never uses one signal as both source and destination.
// [RULE14] Software picks the timer input wired to the chosen block.
// [RULE15] Filtered result may go to pin, interrupt or trigger outputs.
// [RULE16] Timer is a delay counter started by falling input edge, 20 ms.
// [RULE17] Flip-flop state drives the filtered output pin.
// [RULE18] State changes only after input differed for the full delay.
// [RULE19] Each done event loads the flip-flop with its own inverse.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/100ps
module lld_link_debounce #(
  parameter int unsigned DELAY_CYC = lld_pkg::DELAY_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic raw_switch_pin_i,
  input wire logic [4:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic filtered_output_pin_o,
  output logic [5:0] trig_o,
  output logic irq_o
);
  if (DELAY_CYC < 2) begin : g_chk
    $error("DELAY_CYC below 2");
  end
  ////////////////////////////////////////////////////////////
  // Reset release
  logic rst_q1_ff;
  logic rst_q2_ff;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q1_ff <= 1'b0;
      rst_q2_ff <= 1'b0;
    end else begin
      rst_q1_ff <= 1'b1;
      rst_q2_ff <= rst_q1_ff;
    end
  end
  wire rst_n = rst_q2_ff;
  ////////////////////////////////////////////////////////////
  // Register file
  logic [7:0] cfg_ff [0:15];
  logic [7:0] stat_ff;
  logic [7:0] mask_ff;
  logic [7:0] rdata_ff;
  wire [7:0] src0 = cfg_ff[lld_pkg::A_SRC0[3:0]];
  wire [7:0] src1 = cfg_ff[lld_pkg::A_SRC1[3:0]];
  wire [7:0] src6 = cfg_ff[lld_pkg::A_SRC6[3:0]];
  wire [7:0] pk0 = cfg_ff[lld_pkg::A_PICK0[3:0]];
  wire [7:0] pk1 = cfg_ff[lld_pkg::A_PICK1[3:0]];
  wire [7:0] pk2 = cfg_ff[lld_pkg::A_PICK2[3:0]];
  wire [7:0] pk6 = cfg_ff[lld_pkg::A_PICK6[3:0]];
  wire [7:0] rt0 = cfg_ff[lld_pkg::A_ROUTE0[3:0]];
  wire [7:0] rt1 = cfg_ff[lld_pkg::A_ROUTE1[3:0]];
  wire [7:0] rt2 = cfg_ff[lld_pkg::A_ROUTE2[3:0]];
  wire [7:0] rt6 = cfg_ff[lld_pkg::A_ROUTE6[3:0]];
  wire [7:0] ctl = cfg_ff[lld_pkg::A_CTL[3:0]];
  wire [7:0] snk0 = cfg_ff[lld_pkg::A_SINK0[3:0]];
  wire [7:0] snk3 = cfg_ff[lld_pkg::A_SINK3[3:0]];
  wire [7:0] dest = cfg_ff[lld_pkg::A_DEST[3:0]];
  wire [7:0] tcfg = cfg_ff[lld_pkg::A_TCFG[3:0]];
  wire cfg_hit = (addr_i[4] == 1'b0);
  ////////////////////////////////////////////////////////////
  // Fabric helpers
  function automatic logic src_val(input logic [7:0] c, input logic raw, input logic fb,
                                   input logic ev, input logic [7:0] evc);
    src_val = (c == lld_pkg::C_RAW) ? raw : (c == lld_pkg::C_FB) ? fb : (c == evc) ? ev : 1'b0;
  endfunction
  function automatic logic pick(input logic [7:0] c, input logic a, input logic b);
    logic v;
    v = (c[1:0] == lld_pkg::PICK_A) ? a : (c[1:0] == lld_pkg::PICK_B) ? b : 1'b0;
    pick = v ^ c[lld_pkg::PICK_INV_BIT];
  endfunction
  function automatic logic route(input logic [7:0] c, input logic [7:0] tgt, input logic v);
    route = (c == tgt) & v;
  endfunction
  function automatic logic sink(input logic [7:0] c, input logic [7:0] blk);
    sink = (c == 8'h00 || c > 8'h08) ? 1'b0 : blk[3'(c - 8'h01)];
  endfunction
  ////////////////////////////////////////////////////////////
  // Sources
  logic raw_s;
  logic ff1_ff;
  lld_tmr_if tif ();
  lld_sync3 u_sync (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .d_i(raw_switch_pin_i),
    .q_o(raw_s)
  );
  wire [1:0] chan = tcfg[2:1];
  // [RULE12] event of the channel in use
  wire [7:0] ev_code = (chan == lld_pkg::CH1) ? lld_pkg::C_EV1 :
                       (chan == lld_pkg::CH5) ? lld_pkg::C_EV5 : lld_pkg::C_EV0;
  // [RULE1] raw pin source
  wire isel0 = src_val(src0, raw_s, ff1_ff, tif.done, ev_code);
  // [RULE2] feedback source
  wire isel1 = src_val(src1, raw_s, ff1_ff, tif.done, ev_code);
  // [RULE3] timer event source
  wire isel6 = src_val(src6, raw_s, ff1_ff, tif.done, ev_code);
  ////////////////////////////////////////////////////////////
  // Link picks
  // [RULE4] true polarity picks
  wire p0 = pick(pk0, isel0, isel1);
  wire p1 = pick(pk1, isel0, isel1);
  wire p6 = pick(pk6, isel6, 1'b0);
  // [RULE5] inverted feedback pick
  wire p2 = pick(pk2, isel0, isel1);
  // [RULE6] cell 0 inputs
  wire in0 = route(rt0, lld_pkg::ROUTE_IN0, p0) | route(rt1, lld_pkg::ROUTE_IN0, p1) |
             route(rt2, lld_pkg::ROUTE_IN0, p2);
  wire in1 = route(rt0, lld_pkg::ROUTE_IN1, p0) | route(rt1, lld_pkg::ROUTE_IN1, p1) |
             route(rt2, lld_pkg::ROUTE_IN1, p2);
  // [RULE7] flip-flop data
  wire ffd = route(rt0, lld_pkg::ROUTE_FFD, p0) | route(rt1, lld_pkg::ROUTE_FFD, p1) |
             route(rt2, lld_pkg::ROUTE_FFD, p2);
  // [RULE8] flip-flop clock
  wire ffclk = route(rt6, lld_pkg::ROUTE_CLK, p6);
  ////////////////////////////////////////////////////////////
  // Logic cell and flip-flop
  logic cell0;
  // [RULE9] cell function select
  always_comb begin
    case (ctl[1:0])
      lld_pkg::FN_AND: cell0 = in0 & in1;
      lld_pkg::FN_OR: cell0 = in0 | in1;
      lld_pkg::FN_NAND: cell0 = ~(in0 & in1);
      lld_pkg::FN_XOR: cell0 = in0 ^ in1;
      default: cell0 = 1'b0;
    endcase
  end
  wire ff_en = ctl[lld_pkg::CTL_FF_EN_BIT];
  // [RULE19] toggle on done event
  wire ff_load = ffclk & ff_en;
  wire [7:0] blk = {3'h0, ff1_ff, 3'h0, cell0};
  // [RULE18] only a full delay reaches the clock
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ff1_ff <= 1'b0;
    end else if (ff_load) begin
      ff1_ff <= ffd;
    end
  end
  ////////////////////////////////////////////////////////////
  // Sinks
  // [RULE11] timer channel input
  assign tif.lvl = sink(snk3, blk);
  lld_delay_timer #(
    .DELAY_CYC(DELAY_CYC)
  ) u_tmr (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .rise_i(tcfg[lld_pkg::TCFG_EDGE_BIT]),
    .tif(tif)
  );
  // [RULE10] filtered result selection
  wire s0 = sink(snk0, blk);
  logic s0_ff;
  logic pin_ff;
  logic [5:0] trig_ff;
  wire to_pin = (dest[2:0] == lld_pkg::DST_PIN);
  wire s0_rise = s0 & ~s0_ff;
  // Spare top bit takes the unused code 7, so the index never leaves the vector
  logic [7:0] dsel;
  always_comb begin
    dsel = 8'h00;
    dsel[dest[2:0]] = s0_rise;
  end
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s0_ff <= 1'b0;
      pin_ff <= 1'b0;
      trig_ff <= 6'h00;
    end else begin
      s0_ff <= s0;
      // [RULE17] pin follows held state
      if (to_pin) pin_ff <= s0;
      // [RULE15] trigger destinations
      trig_ff <= dsel[6:1];
    end
  end
  ////////////////////////////////////////////////////////////
  // Register access and interrupt
  wire wr_cfg = wr_i & cfg_hit;
  wire wr_stat = wr_i & (addr_i == lld_pkg::A_STAT);
  wire wr_mask = wr_i & (addr_i == lld_pkg::A_MASK);
  wire [7:0] nxt_mask = wr_mask ? wdata_i : mask_ff;
  logic ff1_d;
  wire [7:0] st_set = {6'h00, ff1_ff ^ ff1_d, tif.done};
  // Set wins over a clear in the same cycle
  wire [7:0] nxt_stat = (stat_ff & ~(wr_stat ? wdata_i : 8'h00)) | st_set;
  wire [7:0] state_v = {5'h00, tif.busy, raw_s, ff1_ff};
  wire [7:0] rd_mux = cfg_hit ? cfg_ff[addr_i[3:0]] :
                      (addr_i == lld_pkg::A_STAT) ? stat_ff :
                      (addr_i == lld_pkg::A_MASK) ? mask_ff :
                      (addr_i == lld_pkg::A_STATE) ? state_v : 8'h00;
  logic irq_ff;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) cfg_ff[i] <= lld_pkg::CFG_RST[i];
    end else if (wr_cfg) begin
      cfg_ff[addr_i[3:0]] <= wdata_i;
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff <= lld_pkg::STAT_RST;
      mask_ff <= lld_pkg::MASK_RST;
      rdata_ff <= 8'h00;
      irq_ff <= 1'b0;
      ff1_d <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      rdata_ff <= rd_i ? rd_mux : 8'h00;
      // Next mask too, so a mask write moves the line with the register
      irq_ff <= |(nxt_stat & nxt_mask);
      ff1_d <= ff1_ff;
    end
  end
  assign rdata_o = rdata_ff;
  assign filtered_output_pin_o = pin_ff;
  assign trig_o = trig_ff;
  assign irq_o = irq_ff;
  ////////////////////////////////////////////////////////////
  // Checks
  AST_SRC_RAW: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [RULE1]
    src0 == lld_pkg::C_RAW |-> isel0 == raw_s) else $error("raw source wrong");
  AST_SRC_FB: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [RULE2]
    src1 == lld_pkg::C_FB |-> isel1 == ff1_ff) else $error("feedback source wrong");
  AST_SRC_EV: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [RULE3]
    src6 == lld_pkg::C_EV0 && chan == lld_pkg::CH0 |-> isel6 == tif.done) else $error("event source wrong");
  AST_PICK_INV: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [RULE5]
    pk2 == 8'h82 |-> p2 == !isel1) else $error("inverted pick wrong");
  AST_XOR: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [RULE9]
    ctl == 8'h83 && rt0 == 8'h01 && rt1 == 8'h02 |-> cell0 == (p0 ^ p1)) else $error("cell not xor");
  AST_TOGGLE: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [RULE19]
    ff_load && ffd == !ff1_ff |=> ff1_ff != $past(ff1_ff)) else $error("no toggle");
  AST_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [RULE18]
    !ff_load |=> $stable(ff1_ff)) else $error("state moved without event");
  AST_PIN: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [RULE10]
    to_pin && snk0 == 8'h05 && $stable(snk0) |=> pin_ff == $past(ff1_ff)) else $error("pin not held state");
  AST_TMR_IN: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [RULE11]
    snk3 == 8'h01 |-> tif.lvl == cell0) else $error("timer input wrong");
  AST_IRQ: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    ##1 irq_o == |(stat_ff & mask_ff)) else $error("irq mismatch");
  CV_TOGGLE: cover property (@(posedge ref_clk_i) disable iff (!rst_n) ff_load ##1 $changed(ff1_ff));
  CV_DONE: cover property (@(posedge ref_clk_i) disable iff (!rst_n) tif.done);
  CV_IRQ: cover property (@(posedge ref_clk_i) disable iff (!rst_n) $rose(irq_o));
endmodule // lld_link_debounce

// >>> testbench/lld_switch_model.sv
// Behavioural model of a mechanical push-button switch on the raw pin
`timescale 1ns/100ps
module lld_switch_model (
  input wire logic ref_clk_i,
  output logic pin_o
);
  initial pin_o = 1'b0;
  ////////////////////////////////////////////////////////////
  // Chatter bursts
  // Each bounce pulse stays shorter than the filter delay, so only the settled level may pass
  task automatic bounce(input logic lvl, input int nb, input int hi, input int lo);
    repeat (nb) begin
      @(posedge ref_clk_i);
      pin_o <= lvl;
      repeat (hi) @(posedge ref_clk_i);
      pin_o <= ~lvl;
      repeat (lo) @(posedge ref_clk_i);
    end
    @(posedge ref_clk_i);
    pin_o <= lvl;
  endtask
endmodule // lld_switch_model

// >>> testbench/test_lld_link_debounce.sv
// Self-checking bench of the link debounce fabric
`timescale 1ns/100ps
module test_lld_link_debounce;
  // Short delay keeps the run small; every window below derives from it
  localparam int unsigned DLY = 16;
  logic ref_clk_i, rst_n_i, raw_pin, wr_i, rd_i, filt, irq;
  logic [4:0] addr_i;
  logic [7:0] wdata_i, rdata_o, val;
  logic [5:0] trig_o, seen;
  logic [1:0] chs [0:2] = '{lld_pkg::CH0, lld_pkg::CH1, lld_pkg::CH5};
  logic [7:0] evs [0:2] = '{lld_pkg::C_EV0, lld_pkg::C_EV1, lld_pkg::C_EV5};
  int err_total, cmp_count, n;
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  lld_link_debounce #(.DELAY_CYC(DLY)) dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .raw_switch_pin_i(raw_pin), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .filtered_output_pin_o(filt), .trig_o(trig_o), .irq_o(irq));
  lld_switch_model sw_u (.ref_clk_i(ref_clk_i), .pin_o(raw_pin));
  ////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////
  // Bus cycles: strobes one cycle, read data only in the following cycle
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic chkrd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    chk8(rdata_o, exp);
  endtask
  // Bounded wait for the filtered level; a must-see timeout ends the run
  task automatic wait_pin(input logic exp, input bit must, output int cnt);
    cnt = 0;
    while (cnt < DLY + 12 && filt !== exp) begin
      @(posedge ref_clk_i);
      #1;
      cnt++;
    end
    if (must && filt !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, filt, exp);
      close_out();
    end
  endtask
  task automatic flip(input logic lvl, input int nb);
    sw_u.bounce(lvl, nb, 6, 4);
    wait_pin(lvl, 1'b1, n);
    chk1(n >= DLY, 1'b1);
  endtask
  // Trigger pulses stand one cycle, so every cycle of the window is sampled
  task automatic wait_trig(output logic [5:0] acc);
    acc = '0;
    repeat (DLY + 12) begin
      @(posedge ref_clk_i);
      #1;
      acc = acc | trig_o;
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    rst_n_i = 1'b0;
    addr_i = '0;
    wdata_i = '0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    err_total = 0;
    cmp_count = 0;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    for (int i = 0; i < 16; i++) chkrd(5'(i), lld_pkg::CFG_RST[i]);
    chkrd(lld_pkg::A_STAT, lld_pkg::STAT_RST);
    chkrd(lld_pkg::A_MASK, lld_pkg::MASK_RST);
    wr(5'h13, 8'hFF);
    wr(lld_pkg::A_STATE, 8'hFF);
    chkrd(5'h13, 8'h00);
    chkrd(lld_pkg::A_STATE, 8'h00);
    @(posedge ref_clk_i);
    #1;
    chk8(rdata_o, 8'h00);
    $display("Test registers done");
    // Default falling trigger: count starts when the cell output falls
    sw_u.bounce(1'b1, 0, 6, 4);
    wait_pin(1'b1, 1'b0, n);
    chk1(filt, 1'b0);
    sw_u.bounce(1'b0, 0, 6, 4);
    wait_pin(1'b1, 1'b1, n);
    chk1(n >= DLY, 1'b1);
    sw_u.bounce(1'b1, 0, 6, 4);
    wait_pin(1'b0, 1'b1, n);
    chk1(n >= DLY, 1'b1);
    sw_u.bounce(1'b0, 0, 6, 4);
    wr(lld_pkg::A_TCFG, 8'h01);
    wr(lld_pkg::A_STAT, 8'h03);
    $display("Test falling trigger done");
    flip(1'b1, 3);
    chkrd(lld_pkg::A_STAT, 8'h03);
    chk1(irq, 1'b0);
    wr(lld_pkg::A_MASK, 8'h02);
    @(posedge ref_clk_i);
    #1;
    chk1(irq, 1'b1);
    wr(lld_pkg::A_STAT, 8'h03);
    chkrd(lld_pkg::A_STAT, 8'h00);
    chk1(irq, 1'b0);
    chkrd(lld_pkg::A_STATE, 8'h03);
    flip(1'b0, 3);
    chkrd(lld_pkg::A_STATE, 8'h00);
    $display("Test debounce and interrupt done");
    for (int c = 0; c < 3; c++) begin
      wr(lld_pkg::A_SRC6, evs[c]);
      wr(lld_pkg::A_TCFG, {5'h00, chs[c], 1'b1});
      flip(1'b1, 0);
      flip(1'b0, 0);
    end
    wr(lld_pkg::A_SRC6, lld_pkg::C_EV0);
    wr(lld_pkg::A_TCFG, {5'h00, lld_pkg::CH1, 1'b1});
    sw_u.bounce(1'b1, 0, 6, 4);
    wait_pin(1'b1, 1'b0, n);
    chk1(filt, 1'b0);
    sw_u.bounce(1'b0, 0, 6, 4);
    repeat (6) @(posedge ref_clk_i);
    wr(lld_pkg::A_TCFG, 8'h01);
    $display("Test timer channels done");
    for (int d = 1; d < 7; d++) begin
      wr(lld_pkg::A_DEST, 8'(d));
      sw_u.bounce(1'b1, 0, 6, 4);
      wait_trig(seen);
      chk8({2'b00, seen}, 8'h01 << (d - 1));
      chkrd(lld_pkg::A_STATE, 8'h03);
      sw_u.bounce(1'b0, 0, 6, 4);
      wait_trig(seen);
      chk8({2'b00, seen}, 8'h00);
      chkrd(lld_pkg::A_STATE, 8'h00);
    end
    $display("Test destinations done");
    close_out();
  end
endmodule // test_lld_link_debounce
